/* testbench/config_word_loader_bench.sv */
// Self-checking bench for the configuration word loader
`timescale 1ns/1ps
`default_nettype none
module config_word_loader_bench;
  import cwl_pkg::*;
  logic clk = 1'b0, srst = 1'b1, dev_reset_req = 1'b0, slow = 1'b0;
  logic flash_rd_req, flash_rd_valid, cpu_reset_hold, tbl_ack, osc_pin_function_select;
  logic osc_pin_osc_sel, osc_output_pin_out, osc_output_pin_oe, shared_port_bit_rd;
  logic tbl_rd_en = 1'b0, tbl_wr_en = 1'b0, clk_out_level = 1'b0;
  logic shared_port_bit_lat = 1'b1, shared_port_bit_tris = 1'b0, osc_output_pin_in = 1'b0;
  logic [23:0] flash_rd_addr, flash_rd_data, tbl_addr = 24'h000000;
  logic [15:0] tbl_wdata = 16'h0000, tbl_rdata, w1 = 16'h3c96, w2 = 16'hc3e1;
  logic [1:0] primary_osc_mode;
  int mismatches = 0, compares = 0;
  always #20 clk = ~clk;
  cwl_loader u_cwl_loader (.clk(clk), .srst(srst), .dev_reset_req(dev_reset_req),
    .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
    .cpu_reset_hold(cpu_reset_hold), .tbl_rd_en(tbl_rd_en), .tbl_wr_en(tbl_wr_en),
    .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_ack(tbl_ack),
    .primary_osc_mode(primary_osc_mode), .osc_pin_function_select(osc_pin_function_select),
    .osc_pin_osc_sel(osc_pin_osc_sel), .clk_out_level(clk_out_level),
    .shared_port_bit_lat(shared_port_bit_lat), .shared_port_bit_tris(shared_port_bit_tris),
    .osc_output_pin_in(osc_output_pin_in), .osc_output_pin_out(osc_output_pin_out),
    .osc_output_pin_oe(osc_output_pin_oe), .shared_port_bit_rd(shared_port_bit_rd));
  cwl_flash_model u_cwl_flash_model (.clk(clk), .srst(srst), .flash_rd_req(flash_rd_req),
    .flash_rd_addr(flash_rd_addr), .flash_rd_valid(flash_rd_valid),
    .flash_rd_data(flash_rd_data), .word1_low(w1), .word2_low(w2), .slow(slow));
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_word({23'h0, got}, {23'h0, exp}, m);
  endtask
  task automatic tbl(input logic rd, input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    tbl_rd_en <= rd;
    tbl_wr_en <= !rd;
    tbl_addr <= a;
    tbl_wdata <= d;
    @(posedge clk);
    tbl_rd_en <= 1'b0;
    tbl_wr_en <= 1'b0;
    #1;
    chk_bit(tbl_ack, 1'b1, "table ack");
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] exp);
    tbl(1'b1, a, 16'h0000);
    chk_word(tbl_rdata, exp, "table read");
  endtask
  task automatic wait_load;
    int i;
    i = 0;
    chk_bit(cpu_reset_hold, 1'b1, "hold in reload");
    chk_bit(flash_rd_req, 1'b1, "fetch request");
    chk_word(flash_rd_addr, CWL_WORD1_ADDR_LARGE, "first fetch");
    while (cpu_reset_hold !== 1'b0 && i < 60) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk_bit(cpu_reset_hold, 1'b0, "reload end");
    chk_bit(flash_rd_req, 1'b0, "fetch request end");
  endtask
  task automatic check_locs;
    rd(CWL_CFG_BASE, {8'h00, w1[7:0]});
    rd(24'hf80002, {8'h00, w1[15:8]});
    rd(24'hf80004, {8'h00, w2[7:0] | 8'h1c});
    rd(24'hf80006, {8'h00, w2[15:8]});
    rd(24'hf80008, {8'h00, 6'h3f, w2[1:0]});
  endtask
  task automatic test_load;
    wait_load;
    check_locs;
  endtask
  task automatic test_rev;
    rd(CWL_REV_ADDR, 16'h3042);
    tbl(1'b0, CWL_REV_ADDR, 16'h0000);
    rd(CWL_REV_ADDR, 16'h3042);
    rd(24'hf8000a, 16'h0000);
    rd(24'h7ffffe, 16'h0000);
  endtask
  task automatic test_reload;
    tbl(1'b0, CWL_CFG_BASE, 16'h00aa);
    rd(CWL_CFG_BASE, 16'h00aa);
    w1 <= 16'h5aff;
    w2 <= 16'h0a42;
    slow <= 1'b1;
    @(posedge clk);
    dev_reset_req <= 1'b1;
    @(posedge clk);
    dev_reset_req <= 1'b0;
    #1;
    wait_load;
    check_locs;
  endtask
  task automatic test_pin;
    int m, s;
    logic sel;
    clk_out_level <= 1'b1;
    for (m = 0; m < 4; m++) begin
      for (s = 0; s < 2; s++) begin
        shared_port_bit_lat <= m[0];
        shared_port_bit_tris <= m[1];
        tbl(1'b0, 24'hf80008, {14'h0, m[1:0]});
        tbl(1'b0, 24'hf80004, {10'h0, s[0], 5'h00});
        repeat (2) @(posedge clk);
        #1;
        sel = (m == 2) || (m == 1);
        chk_word({22'h0, primary_osc_mode}, 24'(m), "mode");
        chk_bit(osc_pin_function_select, s[0], "select");
        chk_bit(osc_pin_osc_sel, sel, "osc owns pin");
        chk_bit(osc_output_pin_oe, !sel && (s[0] || !m[1]), "pin drive");
        chk_bit(osc_output_pin_out, !sel && (s[0] || m[0]), "pin value");
      end
    end
  endtask
  task automatic test_pad;
    osc_output_pin_in <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk_bit(shared_port_bit_rd, 1'b1, "pad read high");
    osc_output_pin_in <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk_bit(shared_port_bit_rd, 1'b0, "pad read low");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1;
    test_load;
    test_rev;
    test_reload;
    test_pin;
    test_pad;
    complete_run;
  end
  initial begin
    #(40 * 5000);
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire

/* testbench/cwl_flash_model.sv */
// Behavioural program flash holding the two configuration words
`timescale 1ns/1ps
`default_nettype none
module cwl_flash_model
  import cwl_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic flash_rd_req, // Read request
  input wire logic [23:0] flash_rd_addr, // Word address
  output logic flash_rd_valid, // Data valid pulse
  output logic [23:0] flash_rd_data, // Word data
  input wire logic [15:0] word1_low, // Word 1 low bits
  input wire logic [15:0] word2_low, // Word 2 low bits
  input wire logic slow // Answer late
);
  logic [2:0] cnt;
  always_ff @(posedge clk) begin
    flash_rd_valid <= 1'b0;
    if (srst) begin
      cnt <= 3'h0;
      flash_rd_data <= 24'h000000;
    end else if (flash_rd_req && !flash_rd_valid) begin
      if (cnt >= (slow ? 3'h3 : 3'h0)) begin
        flash_rd_valid <= 1'b1;
        cnt <= 3'h0;
        if (flash_rd_addr == CWL_WORD1_ADDR_LARGE) begin
          flash_rd_data <= {8'hff, word1_low};
        end else if (flash_rd_addr == CWL_WORD2_ADDR_LARGE) begin
          flash_rd_data <= {8'hff, word2_low};
        end else begin
          flash_rd_data <= ~flash_rd_data;
        end
      end else begin
        cnt <= cnt + 3'h1;
        flash_rd_data <= ~flash_rd_data;
      end
    end else if (!flash_rd_valid) begin
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule
`default_nettype wire

/* verilog/cwl_cfg_byte.sv */
// One volatile configuration location
`timescale 1ns/1ps
`default_nettype none
module cwl_cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'hff
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic load, // Loader writes this location
  input wire logic [7:0] load_data, // Unpacked flash byte
  input wire logic wr, // Table write to this location
  input wire logic [7:0] wr_data, // Table write data
  output logic [7:0] q // Current configuration byte
);
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RESET_VAL;
    end else if (load) begin
      q <= load_data;
    end else if (wr) begin
      q <= wr_data;
    end
  end
endmodule
`default_nettype wire

/* verilog/cwl_loader.sv */
// Configuration word loader with table access and oscillator pin control
// Operation
// - A programmed configuration bit reads 0 and an unprogrammed bit reads 1.
// - Configuration bits sit from F80000h in the 800000h-FFFFFFh space, reached only by table access.
// - Configuration is volatile and reloads from the flash words on every kind of device reset.
// - The two source words are fetched from the two highest program memory words.
// - The two packed flash words are unpacked into five configuration locations.
// - The upper byte carries no configuration, so its value never alters behaviour.
// - With oscillator mode 10 or 01 the pin function select is ignored and the pin serves the oscillator.
// - Otherwise a cleared pin function select turns the oscillator pin into a port pin.
// - The revision register shows the major revision in bits 8-6, read only.
// - The revision register shows the minor revision in bits 2-0, read only.
// - Revision register bits 15-12 always read 0011.
// - Revision register bits 11-9 and other unimplemented bits read zero.
`timescale 1ns/1ps
`default_nettype none
module cwl_loader
  import cwl_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1,
  // Arbitrary revision values
  parameter logic [2:0] MAJOR_REV = 3'h1,
  parameter logic [2:0] MINOR_REV = 3'h2
) (
  input wire logic clk, // System clock, 25 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic dev_reset_req, // Any other device reset source, pulse
  output logic flash_rd_req, // Flash read request, level
  output logic [cwl_pkg::CWL_ADDR_W-1:0] flash_rd_addr, // Flash word address
  input wire logic flash_rd_valid, // Flash read data valid, pulse
  input wire logic [23:0] flash_rd_data, // Flash word data
  output logic cpu_reset_hold, // Holds processor in reset
  input wire logic tbl_rd_en, // Table read strobe
  input wire logic tbl_wr_en, // Table write strobe
  input wire logic [cwl_pkg::CWL_ADDR_W-1:0] tbl_addr, // Table address
  input wire logic [cwl_pkg::CWL_DATA_W-1:0] tbl_wdata, // Table write data
  output logic [cwl_pkg::CWL_DATA_W-1:0] tbl_rdata, // Table read data
  output logic tbl_ack, // Table access done, pulse
  output logic [1:0] primary_osc_mode, // Primary oscillator mode
  output logic osc_pin_function_select, // Clock-pin function select
  output logic osc_pin_osc_sel, // Pin given to the oscillator
  input wire logic clk_out_level, // System clock output level
  input wire logic shared_port_bit_lat, // Port latch for the pin
  input wire logic shared_port_bit_tris, // Port direction, 1 input
  input wire logic osc_output_pin_in, // Pin level from the pad
  output logic osc_output_pin_out, // Pin drive value
  output logic osc_output_pin_oe, // Pin drive enable
  output logic shared_port_bit_rd // Synchronised pin level
);
  import cwl_pkg::*;

  cwl_state_type state;
  cwl_state_type next_state;
  logic [23:0] word1;
  logic [23:0] word2;
  logic [7:0] cfg_q [CWL_LOC_N];
  logic [7:0] unpack [CWL_LOC_N];
  logic [CWL_LOC_N-1:0] loc_hit;
  logic [15:0] rev_value;
  logic load_now;
  logic in_cfg_space;
  logic rev_hit;
  logic [15:0] next_rdata;
  logic [23:0] word1_addr;
  logic [23:0] word2_addr;
  logic reset_any;
  logic [7:0] w2_low;
  logic pin_sync;
  logic mode_osc;

  // Flash word addresses for this memory size
  // highest program words
  assign word1_addr = LARGE_MEM ? CWL_WORD1_ADDR_LARGE : CWL_WORD1_ADDR_SMALL;
  assign word2_addr = LARGE_MEM ? CWL_WORD2_ADDR_LARGE : CWL_WORD2_ADDR_SMALL;
  assign flash_rd_req = (state == CWL_ST_REQ1) || (state == CWL_ST_REQ2);
  assign flash_rd_addr = (state == CWL_ST_REQ2) ? word2_addr : word1_addr;

  assign reset_any = srst || dev_reset_req;

  always_comb begin
    next_state = state;
    case (state)
      CWL_ST_REQ1: begin
        if (flash_rd_valid) begin
          next_state = CWL_ST_REQ2;
        end
      end
      CWL_ST_REQ2: begin
        if (flash_rd_valid) begin
          next_state = CWL_ST_UNPACK;
        end
      end
      CWL_ST_UNPACK: begin
        next_state = CWL_ST_DONE;
      end
      CWL_ST_DONE: begin
        next_state = CWL_ST_DONE;
      end
      default: begin
        next_state = CWL_ST_REQ1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset_any) begin
      state <= CWL_ST_REQ1;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      word1 <= {8'hff, CWL_CFG_RESET, CWL_CFG_RESET};
      word2 <= {8'hff, CWL_CFG_RESET, CWL_CFG_RESET};
    end else if (flash_rd_valid && state == CWL_ST_REQ1) begin
      word1 <= flash_rd_data;
    end else if (flash_rd_valid && state == CWL_ST_REQ2) begin
      word2 <= flash_rd_data;
    end
  end

  assign cpu_reset_hold = (state != CWL_ST_DONE);
  assign load_now = (state == CWL_ST_UNPACK);

  // bits 23-16 never reach a location
  // flash bit values pass through unchanged, except word 2 bits 4-2, which are forced to 1
  assign w2_low = word2[7:0] | CWL_W2_UNIMPL_MASK;
  assign unpack[0] = word1[7:0];
  assign unpack[1] = word1[15:8];
  assign unpack[2] = w2_low;
  assign unpack[3] = word2[15:8];
  assign unpack[4] = {6'h3f, word2[1:0]};

  assign in_cfg_space = tbl_addr[CWL_CFG_SPACE_BIT];
  assign rev_hit = in_cfg_space && (tbl_addr == CWL_REV_ADDR);

  genvar gi;
  generate
    for (gi = 0; gi < CWL_LOC_N; gi++) begin : g_loc
      assign loc_hit[gi] = in_cfg_space &&
        (tbl_addr == CWL_CFG_BASE + CWL_CFG_STRIDE * 24'(gi));
      cwl_cfg_byte #(
        .RESET_VAL(CWL_CFG_RESET)
      ) u_byte (
        .clk(clk),
        .srst(srst),
        .load(load_now),
        .load_data(unpack[gi]),
        .wr(tbl_wr_en && loc_hit[gi]),
        .wr_data(tbl_wdata[7:0]),
        .q(cfg_q[gi])
      );
    end
  endgenerate

  assign rev_value = {CWL_REV_RESERVED, 3'h0, MAJOR_REV, 3'h0, MINOR_REV};

  always_comb begin
    next_rdata = 16'h0000;
    if (rev_hit) begin
      next_rdata = rev_value;
    end
    for (int i = 0; i < CWL_LOC_N; i++) begin
      if (loc_hit[i]) begin
        next_rdata = {8'h00, cfg_q[i]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tbl_rdata <= 16'h0000;
      tbl_ack <= 1'b0;
    end else begin
      tbl_ack <= tbl_rd_en || tbl_wr_en;
      if (tbl_rd_en) begin
        tbl_rdata <= next_rdata;
      end
    end
  end

  // Oscillator pin control from location 4 and location 2
  assign primary_osc_mode = cfg_q[4][CWL_POSC_MODE_LSB +: 2];
  assign osc_pin_function_select = cfg_q[2][CWL_PIN_FUNC_BIT];
  assign mode_osc = (primary_osc_mode == CWL_MODE_HS) || (primary_osc_mode == CWL_MODE_XT);
  assign osc_pin_osc_sel = mode_osc;

  cwl_sync3 u_pin_sync (
    .clk(clk),
    .srst(srst),
    .async_in(osc_output_pin_in),
    .sync_out(pin_sync)
  );
  assign shared_port_bit_rd = pin_sync;

  always_ff @(posedge clk) begin
    if (srst) begin
      osc_output_pin_out <= 1'b0;
      osc_output_pin_oe <= 1'b0;
    end else if (mode_osc) begin
      osc_output_pin_out <= 1'b0;
      osc_output_pin_oe <= 1'b0;
    end else if (osc_pin_function_select) begin
      osc_output_pin_out <= clk_out_level;
      osc_output_pin_oe <= 1'b1;
    end else begin
      osc_output_pin_out <= shared_port_bit_lat;
      osc_output_pin_oe <= !shared_port_bit_tris;
    end
  end

  // Checks
  hold_until_done_a: assert property (
    @(posedge clk) disable iff (reset_any)
    (state == CWL_ST_UNPACK) |=> !cpu_reset_hold ##0 $past(cpu_reset_hold))
    else $error("processor released at the wrong time");

  reload_on_reset_a: assert property (
    @(posedge clk) dev_reset_req |=> cpu_reset_hold && state == CWL_ST_REQ1)
    else $error("device reset did not restart the reload");

  fetch_order_a: assert property (
    @(posedge clk) disable iff (reset_any)
    (flash_rd_req && state == CWL_ST_REQ1 && flash_rd_valid)
      |=> flash_rd_req && flash_rd_addr == word2_addr)
    else $error("second word not fetched after the first");

  unpack_word_a: assert property (
    @(posedge clk) disable iff (reset_any)
    load_now |=> cfg_q[0] == word1[7:0] && cfg_q[3] == word2[15:8])
    else $error("flash words not unpacked");

  erased_reads_one_a: assert property (
    @(posedge clk) disable iff (reset_any)
    (load_now && word1[7:0] == 8'hff) |=> cfg_q[0] == 8'hff)
    else $error("unprogrammed bits not read as one");

  upper_ignored_a: assert property (
    @(posedge clk) disable iff (reset_any)
    load_now |=> cfg_q[4][7:2] == 6'h3f && cfg_q[2][4:2] == 3'h7)
    else $error("unused bits not held at one");

  space_decode_a: assert property (
    @(posedge clk) disable iff (srst)
    (tbl_rd_en && !in_cfg_space) |=> tbl_rdata == 16'h0000 && tbl_ack)
    else $error("table read outside configuration space returned data");

  rev_fields_a: assert property (
    @(posedge clk) disable iff (srst)
    (tbl_rd_en && rev_hit) |=> tbl_rdata[8:6] == MAJOR_REV && tbl_rdata[2:0] == MINOR_REV)
    else $error("revision fields wrong");

  rev_reserved_a: assert property (
    @(posedge clk) disable iff (srst)
    (tbl_rd_en && rev_hit) |=> tbl_rdata[15:12] == 4'b0011)
    else $error("revision reserved bits wrong");

  rev_unimpl_a: assert property (
    @(posedge clk) disable iff (srst)
    (tbl_rd_en && rev_hit) |=> tbl_rdata[11:9] == 3'h0 && tbl_rdata[5:3] == 3'h0)
    else $error("revision unimplemented bits not zero");

  osc_owns_pin_a: assert property (
    @(posedge clk) disable iff (srst)
    mode_osc ##1 mode_osc |-> !osc_output_pin_oe)
    else $error("pin driven in crystal mode");

  port_pin_a: assert property (
    @(posedge clk) disable iff (srst)
    (!mode_osc && !osc_pin_function_select)
      |=> osc_output_pin_oe == !$past(shared_port_bit_tris))
    else $error("port direction not applied to the pin");

  pin_clock_out_a: assert property (
    @(posedge clk) disable iff (srst)
    (!mode_osc && osc_pin_function_select)
      |=> osc_output_pin_oe && osc_output_pin_out == $past(clk_out_level))
    else $error("clock output not driven on the pin");

  hold_during_fetch_a: assert property (
    @(posedge clk) disable iff (srst)
    flash_rd_req |-> cpu_reset_hold)
    else $error("processor released while fetching");

  first_fetch_a: assert property (
    @(posedge clk) disable iff (srst)
    dev_reset_req |=> flash_rd_req && flash_rd_addr == word1_addr)
    else $error("reload did not start with the first word");

  ack_follows_strobe_a: assert property (
    @(posedge clk) disable iff (srst)
    (tbl_rd_en || tbl_wr_en) |=> tbl_ack)
    else $error("table access not acknowledged");

  table_write_a: assert property (
    @(posedge clk) disable iff (srst)
    (tbl_wr_en && loc_hit[0] && !load_now) |=> cfg_q[0] == $past(tbl_wdata[7:0]))
    else $error("table write did not reach the location");
endmodule
`default_nettype wire

/* verilog/cwl_pkg.sv */
// Constants for the configuration word loader
package cwl_pkg;
  localparam int CWL_ADDR_W = 24;
  localparam int CWL_DATA_W = 16;
  localparam int CWL_LOC_N = 5;
  // Flash configuration word addresses, largest and smallest memory
  localparam logic [23:0] CWL_WORD1_ADDR_LARGE = 24'h0157fe;
  localparam logic [23:0] CWL_WORD2_ADDR_LARGE = 24'h0157fc;
  localparam logic [23:0] CWL_WORD1_ADDR_SMALL = 24'h00abfe;
  localparam logic [23:0] CWL_WORD2_ADDR_SMALL = 24'h00abfc;
  // Configuration space
  localparam logic [23:0] CWL_CFG_SPACE_BASE = 24'h800000;
  localparam logic [23:0] CWL_CFG_BASE = 24'hf80000;
  localparam logic [23:0] CWL_CFG_STRIDE = 24'h000002;
  localparam logic [23:0] CWL_REV_ADDR = 24'hff0000;
  localparam int CWL_CFG_SPACE_BIT = 23;
  // Unprogrammed value of a configuration byte
  localparam logic [7:0] CWL_CFG_RESET = 8'hff;
  // Word 2 low byte field positions
  localparam int CWL_POSC_MODE_LSB = 0;
  localparam int CWL_PIN_FUNC_BIT = 5;
  localparam logic [7:0] CWL_W2_UNIMPL_MASK = 8'h1c;
  localparam logic [1:0] CWL_MODE_HS = 2'b10;
  localparam logic [1:0] CWL_MODE_XT = 2'b01;
  // Revision register layout
  localparam int CWL_REV_MAJOR_LSB = 6;
  localparam int CWL_REV_MINOR_LSB = 0;
  localparam logic [3:0] CWL_REV_RESERVED = 4'b0011;
  localparam int CWL_REV_RESERVED_LSB = 12;
  typedef enum logic [2:0] {
    CWL_ST_REQ1,
    CWL_ST_REQ2,
    CWL_ST_UNPACK,
    CWL_ST_DONE
  } cwl_state_type;
endpackage

/* verilog/cwl_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cwl_sync3 (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic async_in, // Input from outside the clock domain
  output logic sync_out // Filtered level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule
`default_nettype wire
